/* verilog/awc_pkg.sv */
// Function
// - Low-byte read returns accumulator bits 7:0 after justification formatting.
// - Low-byte write loads the accumulator low byte directly.
// - With shifting on, low-byte upper bits come from the high byte's low bits.
// - Detector compares every result against both programmed limits.
// - Detector reports through a flag in the control register, pollable or interrupt.
// - Less-than limit is 16 bits in two bytes; high byte resets to zeros.
// - Inside test flags when result exceeds greater-than and is below less-than.
// - Outside test flags when result is below lower or above upper limit.
// - Inside or outside depends only on the limit values, no mode bit.
// - Single-ended code is 10-bit unsigned; compare uses the justified form.
// - Left-justified words compare against limits exactly as written.
// - Channel select register routes one positive input to the converter.
// - High-byte read returns accumulator bits 15:8 after formatting.
`default_nettype none
package awc_pkg;
  // ==========================================================================
  // Register addresses.
  localparam logic [7:0] ADDR_CONTROL    = 8'hE8;
  localparam logic [7:0] ADDR_CHANNEL    = 8'hBB;
  localparam logic [7:0] ADDR_JUSTIFY    = 8'hBC;
  localparam logic [7:0] ADDR_RES_LOW    = 8'hBD;
  localparam logic [7:0] ADDR_RES_HIGH   = 8'hBE;
  localparam logic [7:0] ADDR_GT_LOW     = 8'hC3;
  localparam logic [7:0] ADDR_GT_HIGH    = 8'hC4;
  localparam logic [7:0] ADDR_LT_LOW     = 8'hC5;
  localparam logic [7:0] ADDR_LT_HIGH    = 8'hC6;
  // ==========================================================================
  // Reset values and fields.
  localparam logic [7:0] RST_GT_HIGH     = 8'hFF;
  localparam logic [7:0] RST_GT_LOW      = 8'hFF;
  localparam logic [7:0] RST_LT_HIGH     = 8'h00;
  localparam logic [7:0] RST_LT_LOW      = 8'h00;
  localparam logic [4:0] RST_CHANNEL     = 5'h1F;
  localparam logic [2:0] RST_JUSTIFY     = 3'h0;
  localparam logic [15:0] RST_RESULT     = 16'h0000;
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam int         CTL_WINDOW_BIT  = 3;
  localparam int         CTL_SYNC_BIT    = 0;
  // Justify codes: 0 right, 1..3 right with shift by 1..3, 4 left justified.
  localparam logic [2:0] JST_LEFT        = 3'h4;
endpackage
`default_nettype wire

/* verilog/awc_window.sv */
`timescale 1ns/10ps
`default_nettype none
module awc_window (
  // Operands
  input  wire logic [15:0] result,
  input  wire logic [15:0] greater_than_limit,
  input  wire logic [15:0] less_than_limit,
  // Outcome
  output logic             hit
);
  import awc_pkg::*;
  // ==========================================================================
  // Pure comparison; the mode follows from the limit values alone.
  always_comb begin
    if (less_than_limit > greater_than_limit) begin
      hit = (result > greater_than_limit) && (result < less_than_limit);
    end else begin
      hit = (result < less_than_limit) || (result > greater_than_limit);
    end
  end
endmodule
`default_nettype wire

/* verilog/awc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module awc_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Special-function-register bus
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // Converter result path
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  // Status and control outputs
  output logic             window_flag,
  output logic      [4:0]  channel_select,
  output logic             sync_mode
);
  import awc_pkg::*;
  // ==========================================================================
  // Reset release.
  // The reset copy rises on the second edge, so every register leaves
  // reset on the same clock edge and never inside a setup window.
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end
  // ==========================================================================
  // Register state.
  logic [15:0] accum;
  logic [15:0] gt_lim;
  logic [15:0] lt_lim;
  logic [2:0]  justify_shift_select;
  logic [7:0]  control;
  logic [4:0]  chan;
  logic [7:0]  rdata;
  logic        eval_pend;
  logic [15:0] next_accum;
  logic [15:0] next_gt_lim;
  logic [15:0] next_lt_lim;
  logic [2:0]  next_justify;
  logic [7:0]  next_control;
  logic [4:0]  next_chan;
  logic [7:0]  next_rdata;
  logic        next_eval_pend;
  logic [15:0] formatted;
  logic        hit;
  // Formatting of the accumulator as software reads it.
  // Codes 5 to 7 fall back to a plain shift, so no code leaves the read
  // path undefined; software should use only the documented codes.
  always_comb begin
    if (justify_shift_select == JST_LEFT) begin
      formatted = {accum[9:0], 6'h00};
    end else begin
      formatted = accum >> justify_shift_select[1:0];
    end
  end
  // ==========================================================================
  // Window comparison.
  awc_window awc_window_inst (
    .result             (formatted),
    .greater_than_limit (gt_lim),
    .less_than_limit    (lt_lim),
    .hit                (hit)
  );
  // ==========================================================================
  // Next-state logic. A new result beats a same-cycle software write so no
  // conversion is lost; software must keep off the low byte while sync is set.
  always_comb begin
    next_accum     = accum;
    next_gt_lim    = gt_lim;
    next_lt_lim    = lt_lim;
    next_justify   = justify_shift_select;
    next_control   = control;
    next_chan      = chan;
    next_rdata     = rdata;
    next_eval_pend = 1'b0;
    // Unmapped writes fall through and change nothing.
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_RES_LOW:  next_accum[7:0]   = sfr_wdata;
        ADDR_RES_HIGH: next_accum[15:8]  = sfr_wdata;
        ADDR_GT_LOW:   next_gt_lim[7:0]  = sfr_wdata;
        ADDR_GT_HIGH:  next_gt_lim[15:8] = sfr_wdata;
        ADDR_LT_LOW:   next_lt_lim[7:0]  = sfr_wdata;
        ADDR_LT_HIGH:  next_lt_lim[15:8] = sfr_wdata;
        ADDR_JUSTIFY:  next_justify      = sfr_wdata[2:0];
        ADDR_CHANNEL:  next_chan         = sfr_wdata[4:0];
        ADDR_CONTROL:  next_control      = sfr_wdata;
        default: begin
        end
      endcase
    end
    if (conv_done) begin
      next_accum     = conv_data;
      next_eval_pend = 1'b1;
    end
    // Set wins over a software clear in the same cycle.
    if (eval_pend && hit) begin
      next_control[CTL_WINDOW_BIT] = 1'b1;
    end
    // Read data is registered and held until the next read strobe.
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_RES_LOW:  next_rdata = formatted[7:0];
        ADDR_RES_HIGH: next_rdata = formatted[15:8];
        ADDR_GT_LOW:   next_rdata = gt_lim[7:0];
        ADDR_GT_HIGH:  next_rdata = gt_lim[15:8];
        ADDR_LT_LOW:   next_rdata = lt_lim[7:0];
        ADDR_LT_HIGH:  next_rdata = lt_lim[15:8];
        ADDR_JUSTIFY:  next_rdata = {5'h00, justify_shift_select};
        ADDR_CHANNEL:  next_rdata = {3'h0, chan};
        ADDR_CONTROL:  next_rdata = control;
        default:       next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accum                <= RST_RESULT;
      gt_lim               <= {RST_GT_HIGH, RST_GT_LOW};
      lt_lim               <= {RST_LT_HIGH, RST_LT_LOW};
      justify_shift_select <= RST_JUSTIFY;
      control              <= RST_CONTROL;
      chan                 <= RST_CHANNEL;
      rdata                <= 8'h00;
      eval_pend            <= 1'b0;
    end else begin
      accum                <= next_accum;
      gt_lim               <= next_gt_lim;
      lt_lim               <= next_lt_lim;
      justify_shift_select <= next_justify;
      control              <= next_control;
      chan                 <= next_chan;
      rdata                <= next_rdata;
      eval_pend            <= next_eval_pend;
    end
  end
  // ==========================================================================
  // Outputs.
  assign sfr_rdata      = rdata;
  assign window_flag    = control[CTL_WINDOW_BIT];
  assign channel_select = chan;
  assign sync_mode      = control[CTL_SYNC_BIT];
  // ==========================================================================
  // Flag checks. The flag moves only on a pending compare or a control write;
  // a set from the detector wins over a clear in the same cycle.
  flag_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
    eval_pend && hit |=> window_flag) else $error("window flag not set");
  flag_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
    window_flag && !(sfr_wr && sfr_addr == ADDR_CONTROL) |=> window_flag)
    else $error("window flag dropped");
  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_CONTROL && !sfr_wdata[CTL_WINDOW_BIT] && !(eval_pend && hit) |=> !window_flag)
    else $error("window flag not cleared");
  no_spur_a: assert property (@(posedge clk) disable iff (!rst_n)
    !window_flag && !(eval_pend && hit) && !(sfr_wr && sfr_addr == ADDR_CONTROL) |=> !window_flag)
    else $error("window flag spurious");
  eval_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_done |=> !eval_pend)
    else $error("compare pending without a new result");
  new_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done |=> eval_pend && accum == $past(conv_data)) else $error("result not loaded");
  inside_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
    lt_lim > gt_lim |-> hit == (formatted > gt_lim && formatted < lt_lim))
    else $error("inside compare wrong");
  outside_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
    lt_lim <= gt_lim |-> hit == (formatted < lt_lim || formatted > gt_lim))
    else $error("outside compare wrong");
  // ==========================================================================
  // Register checks. Writes land on the next edge; read data stands until
  // the next read strobe.
  low_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_RES_LOW && !conv_done |=> accum[7:0] == $past(sfr_wdata))
    else $error("low byte write lost");
  high_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_RES_HIGH && !conv_done |=> accum[15:8] == $past(sfr_wdata))
    else $error("high byte write lost");
  gt_high_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_GT_HIGH |=> gt_lim[15:8] == $past(sfr_wdata))
    else $error("greater-than high byte write lost");
  gt_low_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_GT_LOW |=> gt_lim[7:0] == $past(sfr_wdata))
    else $error("greater-than low byte write lost");
  lt_high_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_LT_HIGH |=> lt_lim[15:8] == $past(sfr_wdata))
    else $error("less-than high byte write lost");
  lt_low_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_LT_LOW |=> lt_lim[7:0] == $past(sfr_wdata))
    else $error("less-than low byte write lost");
  justify_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_JUSTIFY |=> justify_shift_select == $past(sfr_wdata[2:0]))
    else $error("justify select write lost");
  channel_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_CHANNEL |=> channel_select == $past(sfr_wdata[4:0]))
    else $error("channel select write lost");
  control_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_CONTROL && !(eval_pend && hit) |=> control == $past(sfr_wdata))
    else $error("control write lost");
  low_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == ADDR_RES_LOW |=> sfr_rdata == $past(formatted[7:0]))
    else $error("low byte read wrong");
  high_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == ADDR_RES_HIGH |=> sfr_rdata == $past(formatted[15:8]))
    else $error("high byte read wrong");
  rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  // ==========================================================================
  // Coverage of the main scenarios.
  inside_cov: cover property (@(posedge clk) disable iff (!rst_n) eval_pend && hit && lt_lim > gt_lim);
  outside_cov: cover property (@(posedge clk) disable iff (!rst_n) eval_pend && hit && lt_lim <= gt_lim);
  left_cov: cover property (@(posedge clk) disable iff (!rst_n) conv_done && justify_shift_select == JST_LEFT);
  clear_cov: cover property (@(posedge clk) disable iff (!rst_n) window_flag ##1 !window_flag);
  set_clear_cov: cover property (@(posedge clk) disable iff (!rst_n) eval_pend && hit && sfr_wr && sfr_addr == ADDR_CONTROL);
endmodule
`default_nettype wire

/* test/adc_window_compare_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_window_compare_bench;
  import awc_pkg::*;
  // ==========================================================================
  // Stimulus, observation and bookkeeping.
  localparam int CYCLE_LIMIT = 5000;
  logic        clk, resetn, sfr_wr, sfr_rd, conv_done, window_flag, sync_mode;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [15:0] conv_data;
  logic [4:0]  channel_select;
  int          n_fail, tests_run, cycles;

  awc_top awc_top_inst (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv_done(conv_done), .conv_data(conv_data),
    .window_flag(window_flag), .channel_select(channel_select), .sync_mode(sync_mode));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Shared bus and conversion tasks; inputs move on the falling edge only.
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check(what, {8'h00, exp}, {8'h00, sfr_rdata});
  endtask

  // The flag lands one edge after the result is taken, so look one cycle later.
  task automatic conv(input logic [15:0] d, input logic exp);
    @(negedge clk);
    conv_done = 1'b1;
    conv_data = d;
    @(negedge clk);
    conv_done = 1'b0;
    @(negedge clk);
    check("window_flag", {15'h0000, exp}, {15'h0000, window_flag});
  endtask

  task automatic set_limits(input logic [15:0] gt, input logic [15:0] lt);
    wr(ADDR_GT_HIGH, gt[15:8]);
    wr(ADDR_GT_LOW, gt[7:0]);
    wr(ADDR_LT_HIGH, lt[15:8]);
    wr(ADDR_LT_LOW, lt[7:0]);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    rd(ADDR_GT_HIGH, 8'hFF, "gt_high");
    rd(8'h00, 8'h00, "unmapped");
    rd(ADDR_GT_LOW, RST_GT_LOW, "gt_low");
    rd(ADDR_LT_HIGH, 8'h00, "lt_high");
    rd(ADDR_LT_LOW, RST_LT_LOW, "lt_low");
    rd(ADDR_RES_LOW, 8'h00, "res_low");
    check("channel_select", {11'h000, RST_CHANNEL}, {11'h000, channel_select});
  endtask

  // Sync is still clear whenever the result bytes are written here.
  task automatic t_result_rw;
    wr(ADDR_RES_LOW, 8'hA5);
    wr(ADDR_RES_HIGH, 8'h3C);
    rd(ADDR_RES_LOW, 8'hA5, "res_low");
    rd(ADDR_RES_HIGH, 8'h3C, "res_high");
  endtask

  task automatic t_inside;
    set_limits(16'h0040, 16'h0080);
    conv(16'h0040, 1'b0);
    conv(16'h0080, 1'b0);
    conv(16'h0050, 1'b1);
    conv(16'h0090, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    check("window_flag", 16'h0000, {15'h0000, window_flag});
  endtask

  task automatic t_outside;
    set_limits(16'h0080, 16'h0040);
    conv(16'h0060, 1'b0);
    conv(16'h003F, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    conv(16'h0081, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    conv(16'h0080, 1'b0);
  endtask

  task automatic t_format;
    wr(ADDR_JUSTIFY, 8'h02);
    conv(16'h03FF, 1'b1);
    rd(ADDR_RES_LOW, 8'hFF, "res_low");
    rd(ADDR_RES_HIGH, 8'h00, "res_high");
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_JUSTIFY, {5'h00, JST_LEFT});
    set_limits(16'h003F, 16'h0041);
    conv(16'h0001, 1'b1);
    rd(ADDR_RES_LOW, 8'h40, "res_low");
    rd(ADDR_RES_HIGH, 8'h00, "res_high");
    wr(ADDR_CONTROL, 8'h00);
    set_limits(16'h1000, 16'h2000);
    conv(16'h0030, 1'b0);
    conv(16'h0050, 1'b1);
    rd(ADDR_RES_HIGH, 8'h14, "res_high");
  endtask

  task automatic t_control;
    wr(ADDR_CONTROL, 8'h01);
    check("sync_mode", 16'h0001, {15'h0000, sync_mode});
    wr(ADDR_CHANNEL, 8'h1B);
    check("channel_select", 16'h001B, {11'h000, channel_select});
  endtask

  // ==========================================================================
  // Verdict, watchdog and main sequence.
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    {resetn, sfr_wr, sfr_rd, conv_done, sfr_addr, sfr_wdata, conv_data} = '0;
    {n_fail, tests_run, cycles} = '0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_result_rw();
    t_inside();
    t_outside();
    t_format();
    t_control();
    give_verdict();
  end
endmodule
`default_nettype wire
